// ### hdl/tnt_test_mode_ctl.sv
// Test-mode selector with NAND tree, identifier readout and pad override
// Function
// - Test pin low with request code 0010 enters NAND tree mode; hold-request ignored.
// - Test pin high ends any test mode at once, back to normal.
// - Request code is sampled at test pin's falling edge; mode holds while low except on code 1111.
// - NAND mode floats all outputs except the four grants carrying chain outputs.
// - Pull-ups and pull-downs stay enabled during NAND tree mode.
// - 282 chained pins form four chains of 72, 72, 70 and 68.
// - NAND mode lasts until the test pin goes high, code 1111 is applied or reset asserts.
// - Reset, test pin and first suspend-status pin belong to no chain.
// - Code 1110, hold-request high: device ID on AD31:16, revision on AD7:0.
// - Code 1110, hold-request low: manufacturer ID on all 32 AD bits.
// - Code 1111 with test low cancels any test mode, hold-request ignored.
// - Chain 0 exits on grant 0, elements ordered from host address 25 onward.
`timescale 1ns/1ps
`default_nettype none
module tnt_test_mode_ctl
  import tnt_pkg::*;
#(
  parameter logic [DEV_ID_W-1:0] DEVICE_ID = 16'hA5A5,      // Arbitrary value
  parameter logic [REV_ID_W-1:0] REVISION_ID = 8'h01,       // Arbitrary value
  parameter logic [AD_W-1:0]     MANUFACTURER_ID = 32'h5A5A_0001,  // Arbitrary value
  parameter int                  OTHER_W = 16
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               test_n_i,
  input  wire logic [3:0]         req_n_i,
  input  wire logic               south_hold_request_n_i,
  input  wire tnt_chain_pins_type chain_pins_i,
  input  wire tnt_pad_type        norm_pad_i,
  input  wire logic [OTHER_W-1:0] norm_other_oe_n_i,
  input  wire logic               norm_pull_en_i,
  output tnt_pad_type             pad_o,
  output logic [OTHER_W-1:0]      other_oe_n_o,
  output logic                    pull_en_o,
  output tnt_mode_type            mode_o,
  output logic                    test_active_o
);

  logic            test_n_prev;
  logic            test_fall;
  tnt_mode_type    mode;
  tnt_mode_type    next_mode;
  tnt_mode_type    active_mode;
  logic [AD_W-1:0] ad_id;
  logic [AD_W-1:0] next_ad_id;
  logic [CHAIN_COUNT-1:0] chain_out;
  logic [AD_W-1:0]        pad_ad;
  logic [AD_W-1:0]        pad_ad_oe_n;
  logic [CHAIN_COUNT-1:0] pad_gnt_n;
  logic [CHAIN_COUNT-1:0] pad_gnt_oe_n;

  // Previous test pin level, for the falling-edge detector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      test_n_prev <= TEST_N_RESET;
    end else begin
      test_n_prev <= test_n_i;
    end
  end

  assign test_fall = test_n_prev & ~test_n_i;

  // Code decode at the falling edge; reserved codes leave the device in normal mode
  always_comb begin
    next_mode  = TNT_MODE_NORMAL;
    next_ad_id = AD_ID_RESET;
    case (req_n_i)
      REQ_CODE_NAND: begin
        next_mode = TNT_MODE_NAND;
      end
      REQ_CODE_ID: begin
        if (south_hold_request_n_i) begin
          next_mode  = TNT_MODE_IDREV;
          next_ad_id = {DEVICE_ID, {(AD_W-DEV_ID_W-REV_ID_W){1'b0}}, REVISION_ID};
        end else begin
          next_mode  = TNT_MODE_MFRID;
          next_ad_id = MANUFACTURER_ID;
        end
      end
      default: begin
        next_mode = TNT_MODE_NORMAL;
      end
    endcase
  end

  // Mode register: reset and test release clear it, falling edge loads it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode <= TNT_MODE_NORMAL;
    end else if (test_n_i) begin
      mode <= TNT_MODE_NORMAL;
    end else if (test_fall) begin
      mode <= next_mode;
    end else if (req_n_i == REQ_CODE_DISABLE) begin
      mode <= TNT_MODE_NORMAL;
    end
  end

  // Identifier word, loaded with the mode so both appear on the same edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ad_id <= AD_ID_RESET;
    end else if (!test_n_i && test_fall) begin
      ad_id <= next_ad_id;
    end
  end

  // Gate by the pins themselves: clocks may be stopped, so release must not wait for an edge
  assign active_mode = (rst_n_i && !test_n_i) ? mode : TNT_MODE_NORMAL;

  // Four chains; reset, test and first suspend-status pins are not ports here
  tnt_nand_chain #(.LEN(CHAIN0_LEN)) u_chain0 (
    .pins_i  (chain_pins_i.ch0),
    .chain_o (chain_out[0])
  );
  tnt_nand_chain #(.LEN(CHAIN1_LEN)) u_chain1 (
    .pins_i  (chain_pins_i.ch1),
    .chain_o (chain_out[1])
  );
  tnt_nand_chain #(.LEN(CHAIN2_LEN)) u_chain2 (
    .pins_i  (chain_pins_i.ch2),
    .chain_o (chain_out[2])
  );
  tnt_nand_chain #(.LEN(CHAIN3_LEN)) u_chain3 (
    .pins_i  (chain_pins_i.ch3),
    .chain_o (chain_out[3])
  );

  // Address/data pads: identifier word in both readout modes, floated for the chains
  always_comb begin
    pad_ad      = norm_pad_i.ad;
    pad_ad_oe_n = norm_pad_i.ad_oe_n;
    case (active_mode)
      TNT_MODE_NAND: begin
        pad_ad_oe_n = '1;
      end
      TNT_MODE_IDREV: begin
        pad_ad      = ad_id;
        pad_ad_oe_n = '0;
      end
      TNT_MODE_MFRID: begin
        pad_ad      = ad_id;
        pad_ad_oe_n = '0;
      end
      default: begin
        pad_ad      = norm_pad_i.ad;
        pad_ad_oe_n = norm_pad_i.ad_oe_n;
      end
    endcase
  end

  // Grant pads carry the chain outputs; the only pins left driven in NAND mode
  always_comb begin
    pad_gnt_n    = norm_pad_i.gnt_n;
    pad_gnt_oe_n = norm_pad_i.gnt_oe_n;
    case (active_mode)
      TNT_MODE_NAND: begin
        pad_gnt_n    = chain_out;
        pad_gnt_oe_n = '0;
      end
      default: begin
        pad_gnt_n    = norm_pad_i.gnt_n;
        pad_gnt_oe_n = norm_pad_i.gnt_oe_n;
      end
    endcase
  end

  // Every other output floats in NAND mode; pulls stay on so open pins read defined
  always_comb begin
    other_oe_n_o = norm_other_oe_n_i;
    pull_en_o    = norm_pull_en_i;
    case (active_mode)
      TNT_MODE_NAND: begin
        other_oe_n_o = '1;
        pull_en_o    = 1'b1;
      end
      default: begin
        other_oe_n_o = norm_other_oe_n_i;
        pull_en_o    = norm_pull_en_i;
      end
    endcase
  end

  // Pad word reassembled in the carrier's field order
  assign pad_o = {pad_ad, pad_ad_oe_n, pad_gnt_n, pad_gnt_oe_n};

  assign mode_o        = active_mode;
  assign test_active_o = (active_mode != TNT_MODE_NORMAL);

endmodule : tnt_test_mode_ctl
`default_nettype wire

// ### hdl/tnt_pkg.sv
// Package: constants and carrier types for the test-mode select and NAND tree block
`default_nettype none
package tnt_pkg;

  // Request-pin codes, sampled as REQ[3:0] levels (low-active pins as seen on the wires)
  localparam logic [3:0] REQ_CODE_NAND    = 4'h2;  // 0010
  localparam logic [3:0] REQ_CODE_ID      = 4'hE;  // 1110
  localparam logic [3:0] REQ_CODE_DISABLE = 4'hF;  // 1111

  // Chain lengths, 282 chained pins in total
  localparam int CHAIN0_LEN  = 72;
  localparam int CHAIN1_LEN  = 72;
  localparam int CHAIN2_LEN  = 70;
  localparam int CHAIN3_LEN  = 68;
  localparam int CHAIN_COUNT = 4;

  // Chain 0 first and last documented elements (host address 25, host data 54)
  localparam int CH0_FIRST_ELEM = 0;
  localparam int CH0_LAST_DOC   = 47;

  // Identifier field layout on the address/data pins
  localparam int AD_W          = 32;
  localparam int DEV_ID_LSB    = 16;
  localparam int DEV_ID_W      = 16;
  localparam int REV_ID_W      = 8;

  // Reset values
  localparam logic            TEST_N_RESET = 1'b0;  // Low: a pin held low across reset is no fall
  localparam logic [AD_W-1:0] AD_ID_RESET  = 32'h0000_0000;

  // Test modes held by the selector
  typedef enum logic [1:0] {
    TNT_MODE_NORMAL,
    TNT_MODE_NAND,
    TNT_MODE_IDREV,
    TNT_MODE_MFRID
  } tnt_mode_type;

  // Input levels of every chained pin, element index equals bit index
  typedef struct packed {
    logic [CHAIN3_LEN-1:0] ch3;
    logic [CHAIN2_LEN-1:0] ch2;
    logic [CHAIN1_LEN-1:0] ch1;
    logic [CHAIN0_LEN-1:0] ch0;
  } tnt_chain_pins_type;

  // Pad drive for the address/data and grant pins; enables are low while driving
  typedef struct packed {
    logic [AD_W-1:0]        ad;
    logic [AD_W-1:0]        ad_oe_n;
    logic [CHAIN_COUNT-1:0] gnt_n;
    logic [CHAIN_COUNT-1:0] gnt_oe_n;
  } tnt_pad_type;

endpackage : tnt_pkg
`default_nettype wire

// ### hdl/tnt_nand_chain.sv
// One NAND chain: each pin after the first NANDed with the previous element's output
`timescale 1ns/1ps
`default_nettype none
module tnt_nand_chain #(
  parameter int LEN = 72
) (
  input  wire logic [LEN-1:0] pins_i,
  output logic                chain_o
);

  logic [LEN-1:0] stage;

  // Element 0 sees a constant high partner, so it acts as an inverter
  assign stage[0] = ~pins_i[0];

  // Purely combinational: the clocks are themselves chain pins and stand still
  for (genvar k = 1; k < LEN; k++) begin : g_elem
    assign stage[k] = ~(pins_i[k] & stage[k-1]);
  end

  assign chain_o = stage[LEN-1];

endmodule : tnt_nand_chain
`default_nettype wire

// ### bench/tnt_ate_model.sv
// Tester model driving the test pin, request code and chained pins
`timescale 1ns/1ps
`default_nettype none
module tnt_ate_model
  import tnt_pkg::*;
(
  input  wire logic          clk_i,
  output logic               test_n_o,
  output logic [3:0]         req_n_o,
  output logic               hold_n_o,
  output tnt_chain_pins_type pins_o
);
  // Idle levels; suspend pins in chains 2 and 3 sit high
  initial begin
    test_n_o = 1'b1;
    req_n_o = REQ_CODE_DISABLE;
    hold_n_o = 1'b1;
    pins_o = '1;
  end
  // High one cycle, then low with the code; clocks keep running to enter
  task automatic sel(input logic [3:0] c, input logic h);
    @(posedge clk_i) test_n_o <= 1'b1;
    @(posedge clk_i) test_n_o <= 1'b0;
    req_n_o <= c;
    hold_n_o <= h;
    @(posedge clk_i) #1;
  endtask : sel
  task automatic code(input logic [3:0] c);
    @(posedge clk_i) req_n_o <= c;
  endtask : code
  // Chains are read combinationally, no clock edge needed to judge them
  task automatic pins(input tnt_chain_pins_type p);
    @(posedge clk_i) pins_o <= p;
  endtask : pins
  task automatic rel();
    @(posedge clk_i) test_n_o <= 1'b1;
  endtask : rel
endmodule : tnt_ate_model
`default_nettype wire

// ### bench/tnt_test_mode_ctl_chk.sv
// Port checker for the test-mode selector
`timescale 1ns/1ps
`default_nettype none
module tnt_chk
  import tnt_pkg::*;
#(parameter int OTHER_W = 16) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               test_n_i,
  input wire logic [3:0]         req_n_i,
  input wire logic               south_hold_request_n_i,
  input wire tnt_pad_type        pad_o,
  input wire logic [OTHER_W-1:0] other_oe_n_o,
  input wire logic               pull_en_o,
  input wire tnt_mode_type       mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tp;
  logic fl;
  // Low in reset, so no false fall is seen right after release
  always_ff @(posedge clk_i) tp <= rst_n_i & test_n_i;
  assign fl = tp & ~test_n_i;
  property p_rel; test_n_i |-> mode_o == TNT_MODE_NORMAL; endproperty
  a_rel: assert property (p_rel) else $error("mode with pin high");
  property p_nd; fl && req_n_i == REQ_CODE_NAND |=> test_n_i || mode_o == TNT_MODE_NAND;
  endproperty
  a_nd: assert property (p_nd) else $error("no nand entry");
  property p_idr; fl && req_n_i == REQ_CODE_ID && south_hold_request_n_i
    |=> test_n_i || mode_o == TNT_MODE_IDREV; endproperty
  a_idr: assert property (p_idr) else $error("no id entry");
  property p_mid; fl && req_n_i == REQ_CODE_ID && !south_hold_request_n_i
    |=> test_n_i || mode_o == TNT_MODE_MFRID; endproperty
  a_mid: assert property (p_mid) else $error("no mfr entry");
  property p_flt; mode_o == TNT_MODE_NAND
    |-> &pad_o.ad_oe_n && &other_oe_n_o && pad_o.gnt_oe_n == 4'h0; endproperty
  a_flt: assert property (p_flt) else $error("outputs not floated");
  property p_pul; mode_o == TNT_MODE_NAND |-> pull_en_o; endproperty
  a_pul: assert property (p_pul) else $error("pulls off");
  property p_kp; !test_n_i && !fl && req_n_i != REQ_CODE_DISABLE
    |=> test_n_i || mode_o == $past(mode_o); endproperty
  a_kp: assert property (p_kp) else $error("mode changed");
  property p_cn; !test_n_i && req_n_i == REQ_CODE_DISABLE
    |=> test_n_i || mode_o == TNT_MODE_NORMAL; endproperty
  a_cn: assert property (p_cn) else $error("no cancel");
  c_nd: cover property (fl && req_n_i == REQ_CODE_NAND);
  c_id: cover property (fl && req_n_i == REQ_CODE_ID);
  c_cn: cover property (mode_o != TNT_MODE_NORMAL && req_n_i == REQ_CODE_DISABLE);
endmodule : tnt_chk
bind tnt_test_mode_ctl tnt_chk #(.OTHER_W(OTHER_W)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .test_n_i(test_n_i), .req_n_i(req_n_i), .south_hold_request_n_i(south_hold_request_n_i),
  .pad_o(pad_o), .other_oe_n_o(other_oe_n_o), .pull_en_o(pull_en_o), .mode_o(mode_o));
`default_nettype wire

// ### bench/tnt_test_mode_ctl_test.sv
// Self-checking bench for the test-mode selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tnt_test_mode_ctl_test;
  import tnt_pkg::*;
  localparam logic [31:0] MID = 32'h89AB_CDEF; // Arbitrary value
  localparam logic [15:0] DID = 16'h1234; // Arbitrary value
  localparam logic [7:0]  RID = 8'h56; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic test_n, hold_n, pull, act;
  logic [3:0] req_n;
  logic [15:0] oth;
  tnt_chain_pins_type pins;
  tnt_pad_type pad;
  tnt_mode_type mode;
  tnt_pad_type norm_pad;
  logic [15:0] norm_oe;
  logic norm_pull;
  always #50 clk = ~clk;
  tnt_ate_model m (.clk_i(clk), .test_n_o(test_n), .req_n_o(req_n), .hold_n_o(hold_n),
    .pins_o(pins));
  tnt_test_mode_ctl #(.DEVICE_ID(DID), .REVISION_ID(RID), .MANUFACTURER_ID(MID)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .test_n_i(test_n), .req_n_i(req_n),
    .south_hold_request_n_i(hold_n), .chain_pins_i(pins), .norm_pad_i(norm_pad),
    .norm_other_oe_n_i(norm_oe), .norm_pull_en_i(norm_pull), .pad_o(pad), .other_oe_n_o(oth),
    .pull_en_o(pull), .mode_o(mode), .test_active_o(act));
  // Hang guard: the tests need about 50 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  function automatic logic ch(input logic [71:0] p, input int n);
    logic s;
    s = 1'b1;
    for (int k = 0; k < n; k++) s = ~(p[k] & s);
    return s;
  endfunction : ch
  task automatic t_nand();
    m.sel(REQ_CODE_NAND, 1'b0);
    `CHK("float", {1'b1, 1'b1, 1'b1, 32'hFFFF_FFFF, 4'h0}, {&oth, pull, act, pad.ad_oe_n, pad.gnt_oe_n})
    for (int k = 0; k < 2; k++) begin
      m.pins(k ? {141{2'b10}} : '1);
      #1;
      `CHK("gnt", {ch({4'h0, pins.ch3}, CHAIN3_LEN), ch({2'h0, pins.ch2}, CHAIN2_LEN), ch(pins.ch1, CHAIN1_LEN), ch(pins.ch0, CHAIN0_LEN)}, pad.gnt_n)
    end
    m.code(REQ_CODE_ID);
    @(posedge clk) #1;
    `CHK("hold", TNT_MODE_NAND, mode)
    m.rel();
    #1;
    `CHK("rel", {TNT_MODE_NORMAL, 1'b0}, {mode, pull})
    `CHK("pass", {norm_pad, norm_oe, 1'b0}, {pad, oth, act})
    $display("t_nand done");
  endtask : t_nand
  task automatic t_id();
    for (int h = 0; h < 2; h++) begin
      m.sel(REQ_CODE_ID, h[0]);
      `CHK("ad", {h ? {DID, 8'h00, RID} : MID, 32'h0}, {pad.ad, pad.ad_oe_n})
      m.code(REQ_CODE_DISABLE);
      @(posedge clk) #1;
      `CHK("cancel", TNT_MODE_NORMAL, mode)
      m.rel();
    end
    $display("t_id done");
  endtask : t_id
  task automatic t_rst();
    m.sel(REQ_CODE_NAND, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    #1;
    `CHK("reset", TNT_MODE_NORMAL, mode)
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk) #1;
    `CHK("no fall after reset", TNT_MODE_NORMAL, mode)
    m.sel(REQ_CODE_DISABLE, 1'b1);
    `CHK("disable at fall", TNT_MODE_NORMAL, mode)
    m.rel();
    $display("t_rst done");
  endtask : t_rst
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    norm_pad <= {32'hC3C3_3C3C, 32'h0000_FFFF, 4'hA, 4'h5};
    norm_oe <= 16'h00FF;
    norm_pull <= 1'b0;
    t_nand();
    t_id();
    t_rst();
    summarize();
  end
endmodule : tnt_test_mode_ctl_test
`default_nettype wire
